//--- core/mdp_consts.svh
// Purpose: Named constants for the digital pin function select block
// Assumes: Included by bare name from the design files
// Notes: Shared DIO pin bit 0 is DIO4, bit 7 is DIO11
`ifndef MDP_CONSTS_SVH
`define MDP_CONSTS_SVH

// Pin group widths
`define MDP_COM_W 4
`define MDP_SEG_W 64
`define MDP_DIO_W 8
`define MDP_SPI_W 4
`define MDP_TMUX_W 16

// Segment number of shared DIO bit 0 (DIO n is SEGMENT_DRIVE n+20)
`define MDP_DIO_SEG_BASE 24
// Bits inside the shared DIO group
`define MDP_SCL_BIT 0
`define MDP_SDA_BIT 1
`define MDP_REAL_ENERGY_PULSE_BIT 2
`define MDP_VPULSE_BIT 3
// Slave port pins in segment and bit order
`define MDP_SPI_SEG_BASE 3
`define MDP_SPI_CLK_BIT 0
`define MDP_SPI_OUT_BIT 1
`define MDP_SPI_SEL_BIT 2
`define MDP_SPI_IN_BIT 3
// Slave port returns at reset: only the idle-high select is set
`define MDP_SPI_IN_RST 4'h4
// Segments taken over by the debug port pins
`define MDP_DBG_RST_SEG 32
`define MDP_DBG_CLK_SEG 33
`define MDP_DBG_DAT_SEG 38
// Segments behind the clock test and sync pins
`define MDP_CLOCK_TEST_PIN_SEG 19
`define MDP_MUX_SYNC_PIN_SEG 7

`endif

//--- core/mdp_pkg.sv
// Purpose: Types for the digital pin function select block
// Assumes: Nothing beyond the constants header
// Notes: Mode encodings are left to the tools
package mdp_pkg;

	// Function of the optical transmit pin
	typedef enum logic [1:0]
	{
		MDP_OPTTX_LED,
		MDP_OPTTX_REAL,
		MDP_OPTTX_REACTIVE,
		MDP_OPTTX_DIO
	} mdp_opttx_e;

	// Power mode reported by the power controller
	typedef enum logic [1:0]
	{
		MDP_PWR_MISSION,
		MDP_PWR_BROWNOUT,
		MDP_PWR_LCD,
		MDP_PWR_SLEEP
	} mdp_pwr_e;

endpackage

//--- core/mdp_button_edge.sv
// Purpose: Push-button synchroniser, rising edge flag and wake request
// Assumes: Button level may change at any time
// Notes: Flag is sticky until cleared; a set wins over a clear
`timescale 1ns/10ps
`include "mdp_consts.svh"

module mdp_button_edge
	import mdp_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic chipResetIn,
	// Button and control
	input wire logic buttonIn,
	input wire logic flagClear,
	input wire logic wakeArmed,
	// Results
	output logic buttonIrqFlag,
	output logic wakeRequest
);

	logic syncFirst_reg, syncFirst_next;
	logic syncSecond_reg, syncSecond_next;
	logic prevLevel_reg, prevLevel_next;
	logic flag_reg, flag_next;
	logic wake_reg, wake_next;
	logic riseSeen;

	// Edge is a low sample followed by a high one, both after the sync
	assign riseSeen = syncSecond_reg & ~prevLevel_reg; // R18

	// Next state; first sync stage feeds only the second
	always_comb
	begin
		syncFirst_next = buttonIn;
		syncSecond_next = syncFirst_reg; // R18
		prevLevel_next = syncSecond_reg;
		flag_next = flag_reg;
		if (flagClear)
			flag_next = 1'b0;
		if (riseSeen)
			flag_next = 1'b1; // R13
		wake_next = riseSeen & wakeArmed; // R14
		if (chipResetIn)
		begin
			syncFirst_next = 1'b0;
			syncSecond_next = 1'b0;
			prevLevel_next = 1'b0;
			flag_next = 1'b0;
			wake_next = 1'b0;
		end
	end

	// State registers
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			syncFirst_reg <= 1'b0;
			syncSecond_reg <= 1'b0;
			prevLevel_reg <= 1'b0;
			flag_reg <= 1'b0;
			wake_reg <= 1'b0;
		end
		else
		begin
			syncFirst_reg <= syncFirst_next;
			syncSecond_reg <= syncSecond_next;
			prevLevel_reg <= prevLevel_next;
			flag_reg <= flag_next;
			wake_reg <= wake_next;
		end
	end

	assign buttonIrqFlag = flag_reg;
	assign wakeRequest = wake_reg;

endmodule

//--- core/mdp_pin_select.sv
// Purpose: Function select for the digital pins of a metering SoC
// Assumes: All inputs synchronous to ref_clk except buttonIn
// Notes: Every pin output is registered, so pins lag sources by one cycle
// Notes on behaviour
// (R01) Drive four backplane common outputs
// (R02) Shared pins: segment or general DIO
// (R03) EEPROM mode: DIO4 clock, DIO5 data
// (R04) Pulse mode: DIO6 real, DIO7 reactive
// (R05) Four pins: segments or slave port
// (R06) Debug enable high: debug port, else segments
// (R07) Debug pins off become SEG32, SEG33, SEG38
// (R08) Clock test, sync pins chosen by enables
// (R09) Four-bit select routes signal to test pin
// (R10) Optical receive pin: IR input or DIO
// (R11) Optical transmit: LED, real, reactive, DIO
// (R12) Reset input high resets, low runs
// (R13) Button rising edge sets interrupt flag
// (R14) Button rising edge wakes sleep, LCD modes
// (R15) Production test input held at ground
// (R16) Debug enable pulled low on production
// (R17) Unused shared pins configured as outputs
// (R18) Synchronise button, edge is low then high
`timescale 1ns/10ps
`include "mdp_consts.svh"

module mdp_pin_select
	import mdp_pkg::*;
(
	// Clock and resets
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic chipResetIn,
	// Display driver
	input wire logic [`MDP_COM_W-1:0] lcdCom,
	input wire logic [`MDP_SEG_W-1:0] lcdSeg,
	// Configuration
	input wire logic [`MDP_DIO_W-1:0] dioSelect,
	input wire logic eepromEn,
	input wire logic pulseEn,
	input wire logic slavePortEn,
	input wire logic debugPortEnableIn,
	input wire logic clockTestOutEn,
	input wire logic muxSyncOutEn,
	input wire logic [3:0] testRouteSelect,
	input wire logic optRxDioSel,
	input wire mdp_opttx_e optTxSel,
	input wire mdp_pwr_e powerMode,
	input wire logic buttonFlagClear,
	// Internal signal sources
	input wire logic [`MDP_DIO_W-1:0] dioOutData,
	input wire logic [`MDP_DIO_W-1:0] dioOutEn,
	input wire logic sclDriveLow,
	input wire logic sdaDriveLow,
	input wire logic realEnergyPulse,
	input wire logic reactiveEnergyPulse,
	input wire logic slavePortData,
	input wire logic debugDataOut,
	input wire logic debugDataOutEn,
	input wire logic debugClockOut,
	input wire logic clockTestSrc,
	input wire logic muxSyncSrc,
	input wire logic [`MDP_TMUX_W-1:0] testSignals,
	input wire logic irTxData,
	input wire logic optRxDioOut,
	input wire logic optRxDioOutEn,
	input wire logic optTxDioOut,
	input wire logic optTxDioOutEn,
	// Pins
	output logic [`MDP_COM_W-1:0] backplaneDrive,
	input wire logic [`MDP_DIO_W-1:0] sharedPinIn,
	output logic [`MDP_DIO_W-1:0] sharedPinOut,
	output logic [`MDP_DIO_W-1:0] sharedPinOe,
	input wire logic [`MDP_SPI_W-1:0] slavePinIn,
	output logic [`MDP_SPI_W-1:0] slavePinOut,
	output logic [`MDP_SPI_W-1:0] slavePinOe,
	input wire logic debugResetPinIn,
	output logic debugResetPinOut,
	output logic debugResetPinOe,
	output logic debugClockPin,
	input wire logic debugDataPinIn,
	output logic debugDataPinOut,
	output logic debugDataPinOe,
	output logic clockTestPin,
	output logic muxSyncPin,
	output logic testRoutePin,
	input wire logic opticalReceiveIn,
	output logic opticalReceivePinOut,
	output logic opticalReceivePinOe,
	input wire logic opticalLedPinIn,
	output logic opticalLedOut,
	output logic opticalLedOe,
	input wire logic buttonIn,
	// Returns to the core
	output logic [`MDP_DIO_W-1:0] dioInData,
	output logic sclIn,
	output logic sdaIn,
	output logic slavePortClk,
	output logic slavePortSelectN,
	output logic slavePortIn,
	output logic debugResetIn,
	output logic debugDataIn,
	output logic irRxData,
	output logic optRxDioIn,
	output logic optTxDioIn,
	output logic buttonIrqFlag,
	output logic wakeRequest
);

	logic [`MDP_COM_W-1:0] com_reg, com_next;
	logic [`MDP_DIO_W-1:0] shOut_reg, shOut_next;
	logic [`MDP_DIO_W-1:0] shOe_reg, shOe_next;
	logic [`MDP_DIO_W-1:0] dioIn_reg, dioIn_next;
	logic [`MDP_SPI_W-1:0] spOut_reg, spOut_next;
	logic [`MDP_SPI_W-1:0] spOe_reg, spOe_next;
	logic [`MDP_SPI_W-1:0] spIn_reg, spIn_next;
	logic sclIn_reg, sclIn_next;
	logic sdaIn_reg, sdaIn_next;
	logic dbgRstOut_reg, dbgRstOut_next;
	logic dbgRstOe_reg, dbgRstOe_next;
	logic dbgRstIn_reg, dbgRstIn_next;
	logic dbgClk_reg, dbgClk_next;
	logic dbgDatOut_reg, dbgDatOut_next;
	logic dbgDatOe_reg, dbgDatOe_next;
	logic dbgDatIn_reg, dbgDatIn_next;
	logic clock_test_pin_reg, clock_test_pin_next;
	logic mux_sync_pin_reg, mux_sync_pin_next;
	logic tRoute_reg, tRoute_next;
	logic rxOut_reg, rxOut_next;
	logic rxOe_reg, rxOe_next;
	logic irRx_reg, irRx_next;
	logic rxDioIn_reg, rxDioIn_next;
	logic txOut_reg, txOut_next;
	logic txOe_reg, txOe_next;
	logic txDioIn_reg, txDioIn_next;
	logic wakeArmed;

	// Display commons, shared DIO and slave port pins
	always_comb
	begin
		com_next = lcdCom; // R01
		for (int i = 0; i < `MDP_DIO_W; i++)
		begin
			if (dioSelect[i])
			begin
				shOut_next[i] = dioOutData[i]; // R02
				shOe_next[i] = dioOutEn[i];
			end
			else
			begin
				shOut_next[i] = lcdSeg[`MDP_DIO_SEG_BASE+i]; // R02
				shOe_next[i] = 1'b1;
			end
		end
		// Serial EEPROM lines are open drain: only ever pull low
		if (eepromEn)
		begin
			shOut_next[`MDP_SCL_BIT] = 1'b0; // R03
			shOe_next[`MDP_SCL_BIT] = sclDriveLow;
			shOut_next[`MDP_SDA_BIT] = 1'b0; // R03
			shOe_next[`MDP_SDA_BIT] = sdaDriveLow;
		end
		if (pulseEn)
		begin
			shOut_next[`MDP_REAL_ENERGY_PULSE_BIT] = realEnergyPulse; // R04
			shOe_next[`MDP_REAL_ENERGY_PULSE_BIT] = 1'b1;
			shOut_next[`MDP_VPULSE_BIT] = reactiveEnergyPulse; // R04
			shOe_next[`MDP_VPULSE_BIT] = 1'b1;
		end
		// DIO inputs read as zero on pins not in DIO use; SCL and SDA read high outside EEPROM mode
		dioIn_next = sharedPinIn & dioSelect;
		sclIn_next = eepromEn ? sharedPinIn[`MDP_SCL_BIT] : 1'b1;
		sdaIn_next = eepromEn ? sharedPinIn[`MDP_SDA_BIT] : 1'b1;
		for (int j = 0; j < `MDP_SPI_W; j++)
		begin
			spOut_next[j] = lcdSeg[`MDP_SPI_SEG_BASE+j];
			spOe_next[j] = 1'b1;
		end
		spIn_next = {`MDP_SPI_W{1'b0}};
		spIn_next[`MDP_SPI_SEL_BIT] = 1'b1;
		if (slavePortEn)
		begin
			spOut_next = {`MDP_SPI_W{1'b0}}; // R05
			spOe_next = {`MDP_SPI_W{1'b0}};
			// Data out drives only while the port is selected
			spOut_next[`MDP_SPI_OUT_BIT] = slavePortData;
			spOe_next[`MDP_SPI_OUT_BIT] = ~slavePinIn[`MDP_SPI_SEL_BIT];
			spIn_next = slavePinIn; // R05
			spIn_next[`MDP_SPI_OUT_BIT] = 1'b0;
		end
		if (chipResetIn)
		begin
			com_next = {`MDP_COM_W{1'b0}}; // R12
			shOut_next = {`MDP_DIO_W{1'b0}};
			shOe_next = {`MDP_DIO_W{1'b0}};
			dioIn_next = {`MDP_DIO_W{1'b0}};
			sclIn_next = 1'b1;
			sdaIn_next = 1'b1;
			spOut_next = {`MDP_SPI_W{1'b0}};
			spOe_next = {`MDP_SPI_W{1'b0}};
			spIn_next = {`MDP_SPI_W{1'b0}};
			spIn_next[`MDP_SPI_SEL_BIT] = 1'b1;
		end
	end

	// Registers for commons, shared DIO and slave port
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			com_reg <= {`MDP_COM_W{1'b0}};
			shOut_reg <= {`MDP_DIO_W{1'b0}};
			shOe_reg <= {`MDP_DIO_W{1'b0}};
			dioIn_reg <= {`MDP_DIO_W{1'b0}};
			sclIn_reg <= 1'b1;
			sdaIn_reg <= 1'b1;
			spOut_reg <= {`MDP_SPI_W{1'b0}};
			spOe_reg <= {`MDP_SPI_W{1'b0}};
			spIn_reg <= `MDP_SPI_IN_RST;
		end
		else
		begin
			com_reg <= com_next;
			shOut_reg <= shOut_next;
			shOe_reg <= shOe_next;
			dioIn_reg <= dioIn_next;
			sclIn_reg <= sclIn_next;
			sdaIn_reg <= sdaIn_next;
			spOut_reg <= spOut_next;
			spOe_reg <= spOe_next;
			spIn_reg <= spIn_next;
		end
	end

	// Debug, clock test, sync, test route and optical pins
	always_comb
	begin
		// Debug enable is a strap level, production boards tie it low
		if (debugPortEnableIn) // R16
		begin
			dbgRstOut_next = 1'b0; // R06
			dbgRstOe_next = 1'b0;
			dbgRstIn_next = debugResetPinIn;
			dbgClk_next = debugClockOut;
			dbgDatOut_next = debugDataOut;
			dbgDatOe_next = debugDataOutEn;
			dbgDatIn_next = debugDataPinIn;
		end
		else
		begin
			dbgRstOut_next = lcdSeg[`MDP_DBG_RST_SEG]; // R07
			dbgRstOe_next = 1'b1; // R06
			dbgRstIn_next = 1'b0;
			dbgClk_next = lcdSeg[`MDP_DBG_CLK_SEG]; // R07
			dbgDatOut_next = lcdSeg[`MDP_DBG_DAT_SEG]; // R07
			dbgDatOe_next = 1'b1;
			dbgDatIn_next = 1'b0;
		end
		clock_test_pin_next = clockTestOutEn ? clockTestSrc
			: lcdSeg[`MDP_CLOCK_TEST_PIN_SEG]; // R08
		mux_sync_pin_next = muxSyncOutEn ? muxSyncSrc
			: lcdSeg[`MDP_MUX_SYNC_PIN_SEG]; // R08
		tRoute_next = testSignals[testRouteSelect]; // R09
		if (optRxDioSel)
		begin
			rxOut_next = optRxDioOut; // R10
			rxOe_next = optRxDioOutEn;
			rxDioIn_next = opticalReceiveIn;
			irRx_next = 1'b1;
		end
		else
		begin
			rxOut_next = 1'b0;
			rxOe_next = 1'b0;
			rxDioIn_next = 1'b0;
			irRx_next = opticalReceiveIn; // R10
		end
		txDioIn_next = 1'b0;
		case (optTxSel)
			MDP_OPTTX_LED:
			begin
				txOut_next = irTxData; // R11
				txOe_next = 1'b1;
			end
			MDP_OPTTX_REAL:
			begin
				txOut_next = realEnergyPulse; // R11
				txOe_next = 1'b1;
			end
			MDP_OPTTX_REACTIVE:
			begin
				txOut_next = reactiveEnergyPulse; // R11
				txOe_next = 1'b1;
			end
			MDP_OPTTX_DIO:
			begin
				txOut_next = optTxDioOut; // R11
				txOe_next = optTxDioOutEn;
				txDioIn_next = opticalLedPinIn;
			end
			default:
			begin
				txOut_next = 1'b0;
				txOe_next = 1'b0;
			end
		endcase
		if (chipResetIn)
		begin
			dbgRstOut_next = 1'b0; // R12
			dbgRstOe_next = 1'b0;
			dbgRstIn_next = 1'b0;
			dbgClk_next = 1'b0;
			dbgDatOut_next = 1'b0;
			dbgDatOe_next = 1'b0;
			dbgDatIn_next = 1'b0;
			clock_test_pin_next = 1'b0;
			mux_sync_pin_next = 1'b0;
			tRoute_next = 1'b0;
			rxOut_next = 1'b0;
			rxOe_next = 1'b0;
			rxDioIn_next = 1'b0;
			irRx_next = 1'b1;
			txOut_next = 1'b0;
			txOe_next = 1'b0;
			txDioIn_next = 1'b0;
		end
	end

	// Registers for debug, test and optical pins
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			dbgRstOut_reg <= 1'b0;
			dbgRstOe_reg <= 1'b0;
			dbgRstIn_reg <= 1'b0;
			dbgClk_reg <= 1'b0;
			dbgDatOut_reg <= 1'b0;
			dbgDatOe_reg <= 1'b0;
			dbgDatIn_reg <= 1'b0;
			clock_test_pin_reg <= 1'b0;
			mux_sync_pin_reg <= 1'b0;
			tRoute_reg <= 1'b0;
			rxOut_reg <= 1'b0;
			rxOe_reg <= 1'b0;
			rxDioIn_reg <= 1'b0;
			irRx_reg <= 1'b1;
			txOut_reg <= 1'b0;
			txOe_reg <= 1'b0;
			txDioIn_reg <= 1'b0;
		end
		else
		begin
			dbgRstOut_reg <= dbgRstOut_next;
			dbgRstOe_reg <= dbgRstOe_next;
			dbgRstIn_reg <= dbgRstIn_next;
			dbgClk_reg <= dbgClk_next;
			dbgDatOut_reg <= dbgDatOut_next;
			dbgDatOe_reg <= dbgDatOe_next;
			dbgDatIn_reg <= dbgDatIn_next;
			clock_test_pin_reg <= clock_test_pin_next;
			mux_sync_pin_reg <= mux_sync_pin_next;
			tRoute_reg <= tRoute_next;
			rxOut_reg <= rxOut_next;
			rxOe_reg <= rxOe_next;
			rxDioIn_reg <= rxDioIn_next;
			irRx_reg <= irRx_next;
			txOut_reg <= txOut_next;
			txOe_reg <= txOe_next;
			txDioIn_reg <= txDioIn_next;
		end
	end

	// Wake only matters in the two low-power battery modes
	assign wakeArmed = (powerMode == MDP_PWR_SLEEP)
		| (powerMode == MDP_PWR_LCD); // R14

	// Button edge detector; its outputs are its own flip-flops
	mdp_button_edge u_button
	(
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.chipResetIn(chipResetIn),
		.buttonIn(buttonIn),
		.flagClear(buttonFlagClear),
		.wakeArmed(wakeArmed),
		.buttonIrqFlag(buttonIrqFlag),
		.wakeRequest(wakeRequest)
	);

	// Output wiring straight from the registers
	assign backplaneDrive = com_reg;
	assign sharedPinOut = shOut_reg;
	assign sharedPinOe = shOe_reg; // R17
	assign dioInData = dioIn_reg;
	assign sclIn = sclIn_reg;
	assign sdaIn = sdaIn_reg;
	assign slavePinOut = spOut_reg;
	assign slavePinOe = spOe_reg;
	assign slavePortClk = spIn_reg[`MDP_SPI_CLK_BIT];
	assign slavePortSelectN = spIn_reg[`MDP_SPI_SEL_BIT];
	assign slavePortIn = spIn_reg[`MDP_SPI_IN_BIT];
	assign debugResetPinOut = dbgRstOut_reg;
	assign debugResetPinOe = dbgRstOe_reg;
	assign debugResetIn = dbgRstIn_reg;
	assign debugClockPin = dbgClk_reg;
	assign debugDataPinOut = dbgDatOut_reg;
	assign debugDataPinOe = dbgDatOe_reg;
	assign debugDataIn = dbgDatIn_reg;
	assign clockTestPin = clock_test_pin_reg;
	assign muxSyncPin = mux_sync_pin_reg;
	assign testRoutePin = tRoute_reg;
	assign opticalReceivePinOut = rxOut_reg;
	assign opticalReceivePinOe = rxOe_reg;
	assign irRxData = irRx_reg;
	assign optRxDioIn = rxDioIn_reg;
	assign opticalLedOut = txOut_reg;
	assign opticalLedOe = txOe_reg;
	assign optTxDioIn = txDioIn_reg;

endmodule

//--- testbench/mdp_pin_select_asserts.sv
// Purpose: Port checks for the digital pin function select
// Assumes: Bound to mdp_pin_select, pins lag sources by one clock
// Notes: Checks wait for an edge outside both resets, except a_btn_cause and a_wake (any edge out of reset) and a_chip_reset (edge after a chip reset)
`timescale 1ns/10ps
module mdp_pin_select_asserts
	import mdp_pkg::*;
(
	// Clock and resets
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic chipResetIn,
	// Sources and controls
	input wire logic [3:0] lcdCom,
	input wire logic [63:0] lcdSeg,
	input wire logic debugPortEnableIn,
	input wire logic clockTestOutEn,
	input wire logic clockTestSrc,
	input wire logic [3:0] testRouteSelect,
	input wire logic [15:0] testSignals,
	input wire logic realEnergyPulse,
	input wire mdp_opttx_e optTxSel,
	input wire mdp_pwr_e powerMode,
	input wire logic buttonIn,
	// Pins and returns
	input wire logic [3:0] backplaneDrive,
	input wire logic debugResetPinOut,
	input wire logic debugClockPin,
	input wire logic debugDataPinOut,
	input wire logic clockTestPin,
	input wire logic testRoutePin,
	input wire logic opticalLedOut,
	input wire logic buttonIrqFlag,
	input wire logic wakeRequest
);
	logic armedReg;
	logic armedNext;
	logic routeBit;

	// Pins only track sources once an edge has passed outside reset
	always_comb
	begin
		armedNext = !chipResetIn;
		routeBit = testSignals[testRouteSelect];
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			armedReg <= 1'h0;
		else
			armedReg <= armedNext;
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n || chipResetIn);

	property p_com;
		armedReg |-> backplaneDrive == $past(lcdCom);
	endproperty
	a_com: assert property (p_com) else $error("common drive wrong");

	property p_dbg_off;
		armedReg && !$past(debugPortEnableIn) |->
			debugClockPin == $past(lcdSeg[33]) &&
			debugResetPinOut == $past(lcdSeg[32]) &&
			debugDataPinOut == $past(lcdSeg[38]);
	endproperty
	a_dbg_off: assert property (p_dbg_off) else $error("debug seg wrong");

	property p_clock_test_pin;
		armedReg |-> clockTestPin == ($past(clockTestOutEn) ?
			$past(clockTestSrc) : $past(lcdSeg[19]));
	endproperty
	a_clock_test_pin: assert property (p_clock_test_pin) else $error("clock pin wrong");

	property p_route;
		armedReg |-> testRoutePin == $past(routeBit);
	endproperty
	a_route: assert property (p_route) else $error("route pin wrong");

	property p_led_real;
		armedReg && $past(optTxSel) == MDP_OPTTX_REAL |->
			opticalLedOut == $past(realEnergyPulse);
	endproperty
	a_led_real: assert property (p_led_real) else $error("led pin wrong");

	property p_btn_set;
		armedReg && $rose(buttonIn) |-> ##3 buttonIrqFlag;
	endproperty
	a_btn_set: assert property (p_btn_set) else $error("flag not set");

	property p_btn_cause;
		$rose(buttonIrqFlag) |-> $past(buttonIn, 3);
	endproperty
	a_btn_cause: assert property (p_btn_cause) else $error("flag no edge");

	property p_wake;
		wakeRequest |-> (buttonIrqFlag && ($past(powerMode) == MDP_PWR_LCD
			|| $past(powerMode) == MDP_PWR_SLEEP)) ##1 !wakeRequest;
	endproperty
	a_wake: assert property (p_wake) else $error("wake wrong");

	property p_chip_reset;
		disable iff (!arst_n)
		chipResetIn |=> backplaneDrive == 4'h0 && !buttonIrqFlag;
	endproperty
	a_chip_reset: assert property (p_chip_reset) else $error("no reset");

	c_wake: cover property (wakeRequest);
	c_flag: cover property ($rose(buttonIrqFlag));
	c_dbg: cover property (armedReg && $past(debugPortEnableIn));
endmodule

bind mdp_pin_select mdp_pin_select_asserts u_asserts (.*);

//--- testbench/mdp_far_side.sv
// Purpose: Board side model: pads, optical receiver, push button
// Assumes: Bench commands change at the falling clock edge
// Notes: Released EEPROM lines read high through board pull-ups
`timescale 1ns/10ps
module mdp_far_side
(
	// Clock and bench commands
	input wire logic ref_clk,
	input wire logic press,
	input wire logic [7:0] padLevel,
	input wire logic rxLevel,
	// Device pins
	input wire logic [7:0] sharedPinOut,
	input wire logic [7:0] sharedPinOe,
	input wire logic opticalReceivePinOut,
	input wire logic opticalReceivePinOe,
	output logic [7:0] sharedPinIn,
	output logic opticalReceiveIn,
	output logic buttonIn
);
	// Unused pads are terminated on the board, so none ever floats
	always_comb
	begin
		sharedPinIn = (sharedPinOe & sharedPinOut) |
			(~sharedPinOe & {padLevel[7:2], 2'h3});
		opticalReceiveIn = opticalReceivePinOe ? opticalReceivePinOut
			: rxLevel;
	end

	// Idle button sits at ground until pressed
	initial buttonIn = 1'h0;
	always @(negedge ref_clk)
		buttonIn <= press;
endmodule

//--- testbench/meter_digital_pin_function_select_tb.sv
// Purpose: Random self-checking bench for mdp_pin_select
// Assumes: Inputs change at the falling edge, model runs at rising
// Notes: One chip reset and one async reset are hit mid-run
`timescale 1ns/10ps
module meter_digital_pin_function_select_tb
	import mdp_pkg::*;
;
	logic ref_clk, arst_n, chipResetIn, buttonFlagClear, press, rxLevel;
	logic [3:0] lcdCom, testRouteSelect, slavePinIn, backplaneDrive;
	logic [3:0] slavePinOut, slavePinOe;
	logic [63:0] lcdSeg;
	logic [7:0] dioSelect, dioOutData, dioOutEn, padLevel, sharedPinIn;
	logic [7:0] sharedPinOut, sharedPinOe, dioInData;
	logic [15:0] testSignals;
	logic eepromEn, pulseEn, slavePortEn, debugPortEnableIn, clockTestOutEn;
	logic muxSyncOutEn, optRxDioSel, sclDriveLow, sdaDriveLow;
	logic realEnergyPulse, reactiveEnergyPulse, slavePortData, debugDataOut;
	logic debugDataOutEn, debugClockOut, clockTestSrc, muxSyncSrc, irTxData;
	logic optRxDioOut, optRxDioOutEn, optTxDioOut, optTxDioOutEn;
	logic debugResetPinIn, debugDataPinIn, opticalLedPinIn, opticalReceiveIn;
	logic buttonIn, debugResetPinOut, debugResetPinOe, debugClockPin;
	logic debugDataPinOut, debugDataPinOe, clockTestPin, muxSyncPin;
	logic testRoutePin, opticalLedOut, opticalReceivePinOut;
	logic opticalReceivePinOe, opticalLedOe, sclIn, sdaIn, slavePortClk;
	logic slavePortSelectN, slavePortIn, debugResetIn, debugDataIn;
	logic irRxData, optRxDioIn, optTxDioIn, buttonIrqFlag, wakeRequest;
	mdp_opttx_e optTxSel;
	mdp_pwr_e powerMode;
	logic [7:0] eOut, eOe, eDin, pinSnap;
	logic [3:0] eCom, eSlv, eDbx;
	logic [2:0] eDbg;
	logic [5:0] eAux;
	logic [4:0] eSpx;
	logic eTest, eCk, eSync, eLed, eScl, eIr, eFlag, eWake, eSpe, eDen;
	logic rxSnap, s1, s2, s3;
	logic [159:0] rnd;
	int errCount, checkCount, cyc, k;

	mdp_pin_select dut (.*);
	mdp_far_side far (.*);

	initial
	begin
		ref_clk = 1'h0;
		forever #10 ref_clk = ~ref_clk;
	end

	// Reference model, one edge behind the inputs like the pins
	always @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n || chipResetIn)
		begin
			{eCom, eOut, eOe, eDin, eSlv, eDbg, eTest, eCk, eSync} = '0;
			{eLed, eFlag, eWake, s1, s2, s3, eSpe, eDen} = '0;
			{eScl, eIr} = 2'h3;
			eAux = 6'h01;
			eSpx = 5'h10;
			eDbx = 4'h0;
		end
		else
		begin
			eCom = lcdCom;
			eTest = testSignals[testRouteSelect];
			eCk = clockTestOutEn ? clockTestSrc : lcdSeg[19];
			eSync = muxSyncOutEn ? muxSyncSrc : lcdSeg[7];
			eDen = debugPortEnableIn;
			eDbg = eDen ? {debugDataOut, 1'h0, debugClockOut}
				: {lcdSeg[38], lcdSeg[32], lcdSeg[33]};
			eDbx = eDen ? {debugResetPinIn, debugDataPinIn,
				debugDataOutEn, 1'h0} : 4'h3;
			eSpe = slavePortEn;
			eSlv = eSpe ? {slavePinIn[3], slavePortData, 1'h0, slavePinIn[0]}
				: lcdSeg[6:3];
			eSpx = eSpe ? {slavePinIn[2], 2'h0, ~slavePinIn[2], 1'h0}
				: 5'h1F;
			eScl = eepromEn ? pinSnap[0] : 1'h1;
			eAux = {optRxDioSel ? {rxSnap, optRxDioOutEn, optRxDioOut} : 3'h0,
				optTxSel == MDP_OPTTX_DIO ? {optTxDioOutEn, opticalLedPinIn}
				: 2'h2, eepromEn ? pinSnap[1] : 1'h1};
			eIr = optRxDioSel ? 1'h1 : rxSnap;
			eDin = pinSnap & dioSelect;
			case (optTxSel)
				MDP_OPTTX_LED: eLed = irTxData;
				MDP_OPTTX_REAL: eLed = realEnergyPulse;
				MDP_OPTTX_REACTIVE: eLed = reactiveEnergyPulse;
				default: eLed = optTxDioOut;
			endcase
			// Function enables win over the per-pin select
			for (k = 0; k < 8; k++)
			begin
				eOe[k] = dioSelect[k] ? dioOutEn[k] : 1'h1;
				eOut[k] = dioSelect[k] ? dioOutData[k] : lcdSeg[24 + k];
				// Serial EEPROM lines only ever pull low
				if (eepromEn && k < 2)
				begin
					eOe[k] = (k == 1) ? sdaDriveLow : sclDriveLow;
					eOut[k] = 1'h0;
				end
				if (pulseEn && k > 1 && k < 4)
				begin
					eOe[k] = 1'h1;
					eOut[k] = (k == 2) ? realEnergyPulse : reactiveEnergyPulse;
				end
			end
			eFlag = (eFlag & !buttonFlagClear) | (s2 & !s3);
			eWake = s2 & !s3 & (powerMode == MDP_PWR_LCD
				|| powerMode == MDP_PWR_SLEEP);
			s3 = s2;
			s2 = s1;
			s1 = buttonIn;
		end
	end

	task automatic chk(input string n, input logic [7:0] e, s);
		checkCount++;
		if (s !== e)
		begin
			errCount++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic compare();
		chk("com", 8'(eCom), 8'(backplaneDrive));
		chk("out", eOut, sharedPinOut);
		chk("oe", eOe, sharedPinOe);
		chk("din", eDin, dioInData);
		chk("scl", 8'(eScl), 8'(sclIn));
		chk("slave", 8'(eSlv), eSpe ? 8'({slavePortIn, slavePinOut[1:0],
			slavePortClk}) : 8'(slavePinOut));
		chk("slvx", 8'(eSpx), 8'({slavePortSelectN, slavePinOe}));
		chk("dbg", 8'(eDbg), 8'({debugDataPinOut, debugResetPinOut,
			debugClockPin}));
		chk("dbgx", 8'(eDbx), 8'({debugResetIn, debugDataIn,
			debugDataPinOe, debugResetPinOe}));
		chk("aux", 8'(eAux), 8'({optRxDioIn, opticalReceivePinOe,
			opticalReceivePinOut, opticalLedOe, optTxDioIn,
			sdaIn}));
		chk("ck", 8'({eCk, eSync}), 8'({clockTestPin, muxSyncPin}));
		chk("route", 8'(eTest), 8'(testRoutePin));
		chk("ir", 8'(eIr), 8'(irRxData));
		chk("led", 8'(eLed), 8'(opticalLedOut));
		chk("btn", 8'({eFlag, eWake}), 8'({buttonIrqFlag, wakeRequest}));
	endtask

	// Fresh random inputs; button only moves every fourth cycle
	task automatic drive();
		rnd = {$urandom, $urandom, $urandom, $urandom, $urandom};
		{lcdCom, lcdSeg, dioSelect, dioOutData, dioOutEn, testSignals,
			testRouteSelect, padLevel, slavePinIn, eepromEn, pulseEn,
			slavePortEn, debugPortEnableIn, clockTestOutEn, muxSyncOutEn,
			optRxDioSel, sclDriveLow, sdaDriveLow, realEnergyPulse,
			reactiveEnergyPulse, slavePortData, debugDataOut, debugDataOutEn,
			debugClockOut, clockTestSrc, muxSyncSrc, irTxData, optRxDioOut,
			optRxDioOutEn, optTxDioOut, optTxDioOutEn, debugResetPinIn,
			debugDataPinIn, opticalLedPinIn, rxLevel} = rnd[149:0];
		// Late in the run the strap sits low as on production boards
		if (cyc > 2500)
			debugPortEnableIn = 1'h0;
		buttonFlagClear = &rnd[153:151];
		optTxSel = mdp_opttx_e'(rnd[155:154]);
		powerMode = mdp_pwr_e'(rnd[157:156]);
		#1 pinSnap = sharedPinIn;
		rxSnap = opticalReceiveIn;
		// Button command moves off the edge so the pad model never races
		if (cyc % 4 == 0)
			press = rnd[150];
	endtask

	task automatic completeRun();
		if (errCount == 0 && checkCount > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial
	begin
		void'($urandom(5));
		errCount = 0;
		checkCount = 0;
		cyc = 0;
		arst_n = 1'h0;
		chipResetIn = 1'h0;
		drive();
		repeat (10) @(posedge ref_clk);
		@(negedge ref_clk);
		compare();
		arst_n = 1'h1;
		for (cyc = 1; cyc < 3000; cyc++)
		begin
			@(negedge ref_clk);
			compare();
			chipResetIn = (cyc == 1001);
			arst_n = (cyc < 2001 || cyc > 2002);
			drive();
		end
		completeRun();
	end
endmodule
